// File: common/dpam_pkg.sv
// package: constants, state codes and helpers for the dram address/precharge block
package dpam_pkg;

	// ----------------------------------------------------------------
	// widths and address field positions
	// ----------------------------------------------------------------
	localparam int DRAM_ADDR_W   = 11;
	localparam int CPU_ADDR_W    = 32;
	localparam int ROW_LO_BIT    = 11;
	localparam int COL_LO_BIT    = 4;
	localparam int MID_W         = 9;
	localparam int COLMID_W      = 7;
	localparam int BURST_LO_BIT  = 2;
	localparam int REGION_HI_BIT = 31;
	localparam int REGION_LO_BIT = 30;
	localparam int ROW9_BIT      = 21;
	localparam int ROW10_BIT     = 23;
	localparam int COL9_BIT      = 20;
	localparam int COL10_BIT     = 22;

	localparam logic [1:0] DRAM_REGION   = 2'h0;
	localparam logic [1:0] DEPTH_256K    = 2'h0;
	localparam logic [1:0] DEPTH_1M      = 2'h1;
	localparam logic [1:0] CNT_RESET     = 2'h0;
	localparam logic [1:0] CNT_STEP      = 2'h1;

	// ----------------------------------------------------------------
	// timing: one bus clock of 50 ns
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int PRECHARGE_MIN_CYC_OFF = 1;
	localparam int PRECHARGE_MIN_CYC_ON  = 2;

	// ----------------------------------------------------------------
	// controller states, gray along the usual path
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE        = 4'h0,
		ST_FIRST_DATA  = 4'h1,
		ST_READ_WAIT   = 4'h3,
		ST_FINAL_READ  = 4'h2,
		ST_PRECHARGE   = 4'h6,
		ST_WRITE_WAIT  = 4'h7,
		ST_FINAL_WRITE = 4'h5,
		ST_RFSH1       = 4'h4,
		ST_RFSH2       = 4'hC,
		ST_RFSH3       = 4'hD,
		ST_RFSH4       = 4'hF
	} dpam_state_type;

	function automatic logic dpam_is_refresh(input dpam_state_type s);
		return (s == ST_RFSH1) || (s == ST_RFSH2) || (s == ST_RFSH3) || (s == ST_RFSH4);
	endfunction

	function automatic logic dpam_is_data_end(input dpam_state_type s);
		return (s == ST_FIRST_DATA) || (s == ST_FINAL_READ);
	endfunction

endpackage

// File: common/dpam_ctl_if.sv
// interface: control and counter signals between the controller and its negedge helper
`timescale 1ns/1ps
interface dpam_ctl_if;
	logic       ras;
	logic       load;
	logic [1:0] load_val;
	logic       inc;
	logic       ras_dly;
	logic [1:0] burst_column_counter;

	modport ctl (output ras, output load, output load_val, output inc,
		input ras_dly, input burst_column_counter);
	modport neg (input ras, input load, input load_val, input inc,
		output ras_dly, output burst_column_counter);
endinterface

// File: hdl/dpam_negedge.sv
// module: falling-edge logic, half-clock delayed ras and the burst column counter
`timescale 1ns/1ps
module dpam_negedge
	import dpam_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rstn_i,
	dpam_ctl_if.neg   ctl
);

	logic [1:0] next_cnt;
	logic       next_ras_dly;

	// ----------------------------------------------------------------
	// next values
	// ----------------------------------------------------------------
	always_comb begin
		next_ras_dly = ctl.ras;
		next_cnt     = ctl.burst_column_counter;
		if (ctl.load) begin
			next_cnt = ctl.load_val;
		end else if (ctl.inc) begin
			// two bits are enough, the processor stops a burst at 11
			next_cnt = ctl.burst_column_counter + CNT_STEP;
		end
	end

	// ----------------------------------------------------------------
	// registers on the falling edge
	// ----------------------------------------------------------------
	always_ff @(negedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctl.ras_dly              <= 1'b0;
			ctl.burst_column_counter <= CNT_RESET;
		end else begin
			ctl.ras_dly              <= next_ras_dly;
			ctl.burst_column_counter <= next_cnt;
		end
	end

endmodule // dpam_negedge

// File: hdl/dpam_top.sv
// module: dram row/column address mux, write strobe and ras precharge sequencing
`timescale 1ns/1ps
// Functional notes
// - refresh runs the same states whether fpm or edo is selected.
// - internal ras is off in idle and precharge, on elsewhere.
// - precharge enable on passes through precharge state, else skips it.
// - write strobe is inverted write/read, forced high during refresh.
// - eleven multiplexed address lines carry 22 bits for up to 4M depth.
// - row lines 0-8 carry address 11-19; column lines 2-8 carry 4-10.
// - column lines 1:0 carry address 3:2 on writes, counter on reads.
// - at 4M depth lines 10,9 carry 23,21 in row and 22,20 in column.
// - unused upper lines for smaller depths are driven to zero.
// - mux select is ras delayed half a clock; row while it is off.
// - the burst counter loads address 3:2 at the start of a read.
// - edo: counter increments on falling edge in state after data state.
// - fpm: counter increments one clock later than for edo.
// - dram type alters read timing only; writes are identical.
// - depth field 00 is 256K, 01 is 1M, 1x is 4M.
// - dram request is strobe low with address 31:30 equal to 00.
module dpam_top
	import dpam_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   rstn_i,
	input  wire logic                   cpu_address_strobe_n_i,
	input  wire logic [CPU_ADDR_W-1:0]  cpu_addr_i,
	input  wire logic                   cpu_write_i,
	input  wire logic                   cpu_burst_last_i,
	input  wire logic                   refresh_req_i,
	input  wire logic                   precharge_enable_bit_i,
	input  wire logic [1:0]             depth_sel_i,
	input  wire logic                   edo_mode_i,
	output logic [DRAM_ADDR_W-1:0]      dram_addr_o,
	output logic                        dram_we_n_o,
	output logic                        ras_o,
	output logic                        refresh_cycle_o,
	output logic                        ready_o,
	output dpam_state_type              state_o
);

	dpam_ctl_if ctl_bus ();

	dpam_state_type state;
	dpam_state_type next_state;
	logic           op_read;
	logic           next_op_read;
	logic           after_data;
	logic           next_after_data;
	logic           after_data2;
	logic           next_after_data2;
	logic           dram_req;
	logic           end_state;
	logic           ready;
	logic           next_ready;

	// ----------------------------------------------------------------
	// request decode and operation sequencing
	// ----------------------------------------------------------------
	assign dram_req = !cpu_address_strobe_n_i
		&& (cpu_addr_i[REGION_HI_BIT:REGION_LO_BIT] == DRAM_REGION);

	always_comb begin
		next_state   = state;
		next_op_read = op_read;
		end_state    = 1'b0;
		unique case (state)
			ST_IDLE: begin
				// refresh wins over a simultaneous access request
				if (refresh_req_i) begin
					next_state = ST_RFSH1;
				end else if (dram_req) begin
					next_state   = ST_FIRST_DATA;
					next_op_read = !cpu_write_i;
				end
			end
			ST_FIRST_DATA: begin
				// write path ignores the dram type
				next_state = op_read ? ST_READ_WAIT : ST_WRITE_WAIT;
			end
			ST_READ_WAIT:   next_state = ST_FINAL_READ;
			ST_FINAL_READ: begin
				if (cpu_burst_last_i) begin
					end_state = 1'b1;
				end else begin
					next_state = ST_READ_WAIT;
				end
			end
			ST_WRITE_WAIT:  next_state = ST_FINAL_WRITE;
			ST_FINAL_WRITE: begin
				if (cpu_burst_last_i) begin
					end_state = 1'b1;
				end else begin
					next_state = ST_WRITE_WAIT;
				end
			end
			// refresh path has no dependence on the dram type
			ST_RFSH1:       next_state = ST_RFSH2;
			ST_RFSH2:       next_state = ST_RFSH3;
			ST_RFSH3:       next_state = ST_RFSH4;
			ST_RFSH4:       end_state  = 1'b1;
			ST_PRECHARGE:   next_state = ST_IDLE;
			default:        next_state = ST_IDLE;
		endcase
		if (end_state) begin
			// one idle cycle always; a second precharge cycle when enabled
			next_state = precharge_enable_bit_i ? ST_PRECHARGE : ST_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// burst counter increment timing
	// ----------------------------------------------------------------
	always_comb begin
		next_after_data  = dpam_is_data_end(state);
		next_after_data2 = after_data;
	end

	// ----------------------------------------------------------------
	// ras indication and counter control
	// ----------------------------------------------------------------
	// edo steps in the state after a data state, fpm one clock later
	assign ctl_bus.inc = op_read && !dpam_is_refresh(state) && state != ST_IDLE
		&& (edo_mode_i ? after_data : after_data2);
	assign ctl_bus.load     = (state == ST_FIRST_DATA) && op_read;
	assign ctl_bus.load_val = cpu_addr_i[BURST_LO_BIT+1:BURST_LO_BIT];
	assign ctl_bus.ras      = (state != ST_IDLE) && (state != ST_PRECHARGE);

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			after_data  <= 1'b0;
			after_data2 <= 1'b0;
		end else begin
			after_data  <= next_after_data;
			after_data2 <= next_after_data2;
		end
	end

	// ----------------------------------------------------------------
	// state and ready registers
	// ----------------------------------------------------------------
	// ready is flopped from the next state so it leaves as a clean register output
	always_comb begin
		next_ready = (next_state == ST_FINAL_READ) || (next_state == ST_FINAL_WRITE);
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state   <= ST_IDLE;
			op_read <= 1'b0;
			ready   <= 1'b0;
		end else begin
			state   <= next_state;
			op_read <= next_op_read;
			ready   <= next_ready;
		end
	end

	// ----------------------------------------------------------------
	// falling-edge helper
	// ----------------------------------------------------------------
	dpam_negedge u_negedge (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.ctl    (ctl_bus.neg)
	);

	// ----------------------------------------------------------------
	// address multiplexer
	// ----------------------------------------------------------------
	logic [DRAM_ADDR_W-1:0] row_addr;
	logic [DRAM_ADDR_W-1:0] col_addr;
	logic [1:0]             col_low;
	logic                   depth_4m;
	logic                   depth_1m;

	// 1x decodes to 4M; 01 to 1M; 00 to 256K
	assign depth_4m = depth_sel_i[1];
	assign depth_1m = depth_sel_i == DEPTH_1M;

	// writes use the processor bits, reads the counter, which can run ahead
	assign col_low = cpu_write_i ? cpu_addr_i[BURST_LO_BIT+1:BURST_LO_BIT]
		: ctl_bus.burst_column_counter;

	always_comb begin
		row_addr = '0;
		col_addr = '0;
		row_addr[MID_W-1:0] = cpu_addr_i[ROW_LO_BIT+MID_W-1:ROW_LO_BIT];
		col_addr[MID_W-1:2] = cpu_addr_i[COL_LO_BIT+COLMID_W-1:COL_LO_BIT];
		col_addr[1:0]       = col_low;
		if (depth_4m || depth_1m) begin
			row_addr[9] = cpu_addr_i[ROW9_BIT];
			col_addr[9] = cpu_addr_i[COL9_BIT];
		end
		if (depth_4m) begin
			row_addr[10] = cpu_addr_i[ROW10_BIT];
			col_addr[10] = cpu_addr_i[COL10_BIT];
		end
	end

	// ----------------------------------------------------------------
	// row/column select per line
	// ----------------------------------------------------------------
	// select follows ras delayed by half a clock, so the row still stands at the ras edge
	generate
		for (genvar g = 0; g < DRAM_ADDR_W; g++) begin : g_line
			assign dram_addr_o[g] = ctl_bus.ras_dly ? col_addr[g] : row_addr[g];
		end
	endgenerate

	// ----------------------------------------------------------------
	// write strobe and status
	// ----------------------------------------------------------------
	// strobe held high in refresh for older parts that sample it at ras fall
	assign dram_we_n_o     = dpam_is_refresh(state) | !cpu_write_i;
	assign refresh_cycle_o = dpam_is_refresh(state);
	assign ras_o           = ctl_bus.ras;
	assign ready_o         = ready;
	assign state_o         = state;

endmodule // dpam_top

// File: bench/dpam_dram_model.sv
// partner: dram side that latches the row address at the start of each ras period
`timescale 1ns/1ps
module dpam_dram_model
	import dpam_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   ras_i,
	input  wire logic [DRAM_ADDR_W-1:0] addr_i,
	output logic      [DRAM_ADDR_W-1:0] row_o
);
	logic ras_q = 1'b0;
	// the row is strobed on the ras edge, so it must already stand there
	always @(posedge clk_i) begin
		#1;
		if (ras_i && !ras_q) begin
			row_o = addr_i;
		end
		ras_q = ras_i;
	end
endmodule // dpam_dram_model

// File: bench/dpam_top_sva.sv
// checker: port-level properties of the dram address and precharge block
`timescale 1ns/1ps
module dpam_top_sva
	import dpam_pkg::*;
(
	input wire logic                   clk_i,
	input wire logic                   rstn_i,
	input wire logic                   cpu_address_strobe_n_i,
	input wire logic [CPU_ADDR_W-1:0]  cpu_addr_i,
	input wire logic                   cpu_write_i,
	input wire logic                   refresh_req_i,
	input wire logic                   precharge_enable_bit_i,
	input wire logic [1:0]             depth_sel_i,
	input wire logic [DRAM_ADDR_W-1:0] dram_addr_o,
	input wire logic                   dram_we_n_o,
	input wire logic                   ras_o,
	input wire logic                   refresh_cycle_o,
	input wire logic                   ready_o,
	input wire dpam_state_type         state_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	logic idle;
	logic wt;
	assign idle = state_o == ST_IDLE;
	assign wt = state_o inside {ST_READ_WAIT, ST_WRITE_WAIT};
	property p_ras; ras_o == !(idle || state_o == ST_PRECHARGE); endproperty
	a_ras: assert property (p_ras)
		else $error("ras level wrong for state");
	property p_pre_on; precharge_enable_bit_i && $fell(ras_o) |-> state_o == ST_PRECHARGE ##1 idle;
	endproperty
	a_pre_on: assert property (p_pre_on)
		else $error("precharge state not taken");
	property p_pre_off; !precharge_enable_bit_i && $fell(ras_o) |-> idle; endproperty
	a_pre_off: assert property (p_pre_off)
		else $error("precharge state not skipped");
	property p_we;
		dram_we_n_o == (state_o inside {ST_RFSH1, ST_RFSH2, ST_RFSH3, ST_RFSH4} || !cpu_write_i);
	endproperty
	a_we: assert property (p_we)
		else $error("write strobe wrong");
	property p_row; idle |-> dram_addr_o[8:0] == cpu_addr_i[19:11]; endproperty
	a_row: assert property (p_row)
		else $error("row address wrong");
	property p_col; wt |-> dram_addr_o[8:2] == cpu_addr_i[10:4]; endproperty
	a_col: assert property (p_col)
		else $error("column address wrong");
	property p_wlow; wt && cpu_write_i |-> dram_addr_o[1:0] == cpu_addr_i[3:2]; endproperty
	a_wlow: assert property (p_wlow)
		else $error("write column low bits wrong");
	property p_up; idle && depth_sel_i[1] |-> dram_addr_o[10:9] == {cpu_addr_i[23], cpu_addr_i[21]};
	endproperty
	a_up: assert property (p_up)
		else $error("upper row lines wrong");
	property p_zero; !depth_sel_i[1] |-> !dram_addr_o[10] && (depth_sel_i[0] || !dram_addr_o[9]);
	endproperty
	a_zero: assert property (p_zero)
		else $error("unused upper lines not zero");
	property p_req;
		idle && !refresh_req_i && !cpu_address_strobe_n_i && cpu_addr_i[31:30] == DRAM_REGION
			|=> state_o == ST_FIRST_DATA ##2 ready_o;
	endproperty
	a_req: assert property (p_req)
		else $error("dram request not taken");
	property p_rfsh;
		idle && refresh_req_i |=> state_o == ST_RFSH1 ##1 state_o == ST_RFSH2
			##1 state_o == ST_RFSH3 ##1 state_o == ST_RFSH4;
	endproperty
	a_rfsh: assert property (p_rfsh)
		else $error("refresh sequence wrong");
	c_pre: cover property (state_o == ST_PRECHARGE);
	c_wr: cover property (ready_o && cpu_write_i);
	c_rfsh: cover property (state_o == ST_RFSH4);
	c_burst: cover property (state_o == ST_FINAL_READ ##1 state_o == ST_READ_WAIT);
endmodule // dpam_top_sva

bind dpam_top dpam_top_sva u_sva (.clk_i(clk_i), .rstn_i(rstn_i),
	.cpu_address_strobe_n_i(cpu_address_strobe_n_i), .cpu_addr_i(cpu_addr_i),
	.cpu_write_i(cpu_write_i), .refresh_req_i(refresh_req_i),
	.precharge_enable_bit_i(precharge_enable_bit_i), .depth_sel_i(depth_sel_i),
	.dram_addr_o(dram_addr_o), .dram_we_n_o(dram_we_n_o), .ras_o(ras_o),
	.refresh_cycle_o(refresh_cycle_o), .ready_o(ready_o), .state_o(state_o));

// File: bench/tb_dpam_top.sv
// testbench: self-checking bench for the dram address and precharge block
`timescale 1ns/1ps
module tb_dpam_top;
	import dpam_pkg::*;
	logic clk_i = 0, rstn_i = 0, strobe_n = 1, wr = 0, rfq = 0, pre = 0, edo = 0;
	logic last = 1;
	logic [31:0] addr = '0;
	logic [1:0] depth = '0;
	logic [10:0] daddr, row;
	logic we_n, ras, rfc, rdy;
	dpam_state_type st;
	logic [21:0] exp_q[$];
	int bad_count = 0, num_checks = 0, cycles = 0;
	always #25 clk_i = ~clk_i;
	dpam_top DUT (.clk_i(clk_i), .rstn_i(rstn_i), .cpu_address_strobe_n_i(strobe_n),
		.cpu_addr_i(addr), .cpu_write_i(wr), .cpu_burst_last_i(last), .refresh_req_i(rfq),
		.precharge_enable_bit_i(pre), .depth_sel_i(depth), .edo_mode_i(edo),
		.dram_addr_o(daddr), .dram_we_n_o(we_n), .ras_o(ras), .refresh_cycle_o(rfc),
		.ready_o(rdy), .state_o(st));
	dpam_dram_model u_mem (.clk_i(clk_i), .ras_i(ras), .addr_i(daddr), .row_o(row));
	task automatic check(input logic [21:0] seen, input logic [21:0] want);
		num_checks++;
		if (seen !== want) begin
			bad_count++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic print_verdict();
		if (bad_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wait_idle();
		int n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (st !== ST_IDLE && n < 20);
		check(22'(n < 20), 22'h1);
	endtask
	task automatic do_op(input logic w, e, p, input logic [1:0] d, hi);
		logic [31:0] a;
		logic [1:0] lo;
		int beats;
		a = {2'h0, 30'($urandom)};
		a[3:2] = a[3:2] | hi;
		// the processor stops a burst at word 11, so each burst runs up to there
		beats = 4 - int'(a[3:2]);
		for (int k = 0; k < beats; k++) begin
			// reads show the counter: one step ahead for edo, still unstepped for fpm
			lo = a[3:2] + 2'(k) + 2'(!w && e);
			exp_q.push_back({d[1] & a[23], |d & a[21], a[19:11],
				d[1] & a[22], |d & a[20], a[10:4], lo});
		end
		@(negedge clk_i);
		{last, wr, edo, pre, depth, addr, strobe_n} <= {beats == 1, w, e, p, d, a, 1'b0};
		@(negedge clk_i);
		strobe_n <= 1'b1;
		@(negedge clk_i);
		// next word in each wait state, last flagged for the final beat
		for (int k = 1; k < beats; k++) begin
			repeat (2) @(negedge clk_i);
			{last, addr[3:2]} <= {k == beats - 1, a[3:2] + 2'(k)};
		end
		wait_idle();
	endtask
	always @(posedge clk_i) begin
		#5;
		if (rdy === 1'b1) begin
			if (exp_q.size() == 0)
				check(22'h3f_ffff, 22'h0);
			else
				check({row, daddr}, exp_q.pop_front());
			check(22'(we_n), 22'(!wr));
		end
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(2319));
		repeat (20) @(posedge clk_i);
		@(negedge clk_i);
		rstn_i <= 1'b1;
		for (int i = 0; i < 32; i++)
			do_op(i[0], i[1], i[2], i[4:3], {2{i[4]}});
		for (int e = 0; e < 2; e++) begin
			{wr, edo, rfq} <= {1'b1, e[0], 1'b1};
			@(negedge clk_i);
			rfq <= 1'b0;
			repeat (4) begin
				check(22'({rfc, we_n}), 22'h3);
				@(negedge clk_i);
			end
			wait_idle();
		end
		{addr, strobe_n} <= {32'h4000_0000, 1'b0};
		@(negedge clk_i);
		strobe_n <= 1'b1;
		@(negedge clk_i);
		check(22'(st), 22'(ST_IDLE));
		print_verdict();
	end
endmodule // tb_dpam_top
